// [rtl/pcfg_pkg.sv]
// Constants shared by the two-port configuration and data block
package pcfg_pkg;

  // ==========================================================
  // Widths
  // ==========================================================
  localparam int PCFG_DW = 8;           // Data width of one port
  localparam int PCFG_AW = 8;           // Register address width
  localparam int PCFG_BW = 3;           // Bit select width

  // ==========================================================
  // Register addresses
  // ==========================================================
  localparam logic [7:0] PCFG_PAGE_CFG   = 8'h0F; // Config page
  localparam logic [7:0] PCFG_ADR_P1     = 8'h90; // Port one data
  localparam logic [7:0] PCFG_ADR_P2     = 8'hA0; // Port two data
  localparam logic [7:0] PCFG_ADR_P1DRV  = 8'hA5; // Port one driver
  localparam logic [7:0] PCFG_ADR_P2DRV  = 8'hA6; // Port two driver
  localparam logic [7:0] PCFG_ADR_P1BYP  = 8'hD5; // Port one bypass
  localparam logic [7:0] PCFG_ADR_P1ANA  = 8'hF2; // Port one mode
  localparam logic [7:0] PCFG_ADR_P2ANA  = 8'hF3; // Port two mode

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] PCFG_RST_DATA = 8'hFF; // Latches high
  localparam logic [7:0] PCFG_RST_ANA  = 8'hFF; // All digital
  localparam logic [7:0] PCFG_RST_DRV  = 8'h00; // All open-drain
  localparam logic [7:0] PCFG_RST_BYP  = 8'h00; // None bypassed
  localparam logic [7:0] PCFG_ZERO     = 8'h00; // Unmapped read

endpackage

// [rtl/pcfg_top.sv]
// Register and pin-control logic for two 8-bit general-purpose ports
`timescale 1ns/100ps
// Overview of operation
// (RULE1) Data write loads each pin output latch
// (RULE2) Data read returns sampled pin levels
// (RULE3) Analog cells report no valid digital level
// (RULE4) Data registers at 0x90/0xA0, all pages, bitwise
// (RULE5) Mode and bypass registers only on page 0x0F
// (RULE6) Mode bit 0 analog, 1 digital
// (RULE7) Analog mode kills pull-up and receiver
// (RULE8) Software clears driver bit for analog pins
// (RULE9) Driver bit ignored while pin is analog
// (RULE10) Driver bit 0 open-drain, 1 push-pull
// (RULE11) Bypass bit 1 makes crossbar skip pin
// (RULE12) Software bypasses analog, special, plain pins
// (RULE13) Port two driver register at 0xA6, same coding
// (RULE14) Config registers read back last written value
// (RULE15) Reset: data, mode ones; driver, bypass zeros
module pcfg_top (
  input  wire logic                          i_clock,
  input  wire logic                          i_rst_n,
  // Register bus from the core
  input  wire logic [pcfg_pkg::PCFG_AW-1:0]  i_sfr_page,
  input  wire logic [pcfg_pkg::PCFG_AW-1:0]  i_sfr_addr,
  input  wire logic                          i_sfr_wr,
  input  wire logic [pcfg_pkg::PCFG_DW-1:0]  i_sfr_wdata,
  input  wire logic                          i_sfr_bit_wr,
  input  wire logic [pcfg_pkg::PCFG_BW-1:0]  i_sfr_bit_sel,
  input  wire logic                          i_sfr_bit_val,
  input  wire logic                          i_sfr_rd,
  output logic      [pcfg_pkg::PCFG_DW-1:0]  o_sfr_rdata,
  output logic                               o_sfr_hit,
  // Pad levels seen at the pins
  input  wire logic [pcfg_pkg::PCFG_DW-1:0]  i_port_one_pin,
  input  wire logic [pcfg_pkg::PCFG_DW-1:0]  i_port_two_pin,
  // Pad controls, port one
  output logic      [pcfg_pkg::PCFG_DW-1:0]  o_port_one_out,
  output logic      [pcfg_pkg::PCFG_DW-1:0]  o_port_one_oe,
  output logic      [pcfg_pkg::PCFG_DW-1:0]  o_port_one_pullup,
  output logic      [pcfg_pkg::PCFG_DW-1:0]  o_port_one_rx_en,
  // Pad controls, port two
  output logic      [pcfg_pkg::PCFG_DW-1:0]  o_port_two_out,
  output logic      [pcfg_pkg::PCFG_DW-1:0]  o_port_two_oe,
  output logic      [pcfg_pkg::PCFG_DW-1:0]  o_port_two_pullup,
  output logic      [pcfg_pkg::PCFG_DW-1:0]  o_port_two_rx_en,
  // Crossbar steering
  output logic      [pcfg_pkg::PCFG_DW-1:0]  o_port_one_skip
);
  import pcfg_pkg::*;

  // ==========================================================
  // Register state
  // ==========================================================
  logic [PCFG_DW-1:0] port_one_pins;            // Port one latch
  logic [PCFG_DW-1:0] port_two_pins;            // Port two latch
  logic [PCFG_DW-1:0] port_one_analog_select;   // Port one mode
  logic [PCFG_DW-1:0] port_two_analog_select;   // Port two mode
  logic [PCFG_DW-1:0] port_one_driver_type;     // Port one driver
  logic [PCFG_DW-1:0] port_two_driver_type;     // Port two driver
  logic [PCFG_DW-1:0] port_one_crossbar_bypass; // Port one bypass

  // ==========================================================
  // Decode helpers
  // ==========================================================
  // Register visible on every page
  function automatic logic hit_any(
    input logic [PCFG_AW-1:0] addr,
    input logic [PCFG_AW-1:0] want
  );
    hit_any = (addr == want);
  endfunction

  // Register visible only on the configuration page
  function automatic logic hit_cfg(
    input logic [PCFG_AW-1:0] page,
    input logic [PCFG_AW-1:0] addr,
    input logic [PCFG_AW-1:0] want
  );
    hit_cfg = (page == PCFG_PAGE_CFG) && (addr == want); // RULE5
  endfunction

  // One-hot mask for a single-bit write
  function automatic logic [PCFG_DW-1:0] bit_mask(
    input logic [PCFG_BW-1:0] sel
  );
    bit_mask = PCFG_DW'(1) << sel;
  endfunction

  // Next latch value from byte or bit write
  function automatic logic [PCFG_DW-1:0] latch_next(
    input logic [PCFG_DW-1:0] cur,
    input logic               wr,
    input logic [PCFG_DW-1:0] wdata,
    input logic               bwr,
    input logic [PCFG_BW-1:0] sel,
    input logic               bval
  );
    logic [PCFG_DW-1:0] m;
    m = bit_mask(sel);
    if (wr) begin
      latch_next = wdata;                                 // RULE1
    end else if (bwr) begin
      // Only the addressed bit moves, others keep
      latch_next = bval ? (cur | m) : (cur & ~m);         // RULE4
    end else begin
      latch_next = cur;
    end
  endfunction

  // Output enable per pin; analog pins behave open-drain
  function automatic logic [PCFG_DW-1:0] drive_en(
    input logic [PCFG_DW-1:0] latch,
    input logic [PCFG_DW-1:0] ana,
    input logic [PCFG_DW-1:0] drv
  );
    logic [PCFG_DW-1:0] pp;
    pp = drv & ana;                                       // RULE9
    // Push-pull drives always, open-drain only the low
    drive_en = pp | ~latch;                               // RULE10
  endfunction

  // ==========================================================
  // Address decode of the current access
  // ==========================================================
  logic sel_p1;     // Port one data
  logic sel_p2;     // Port two data
  logic sel_p1ana;  // Port one mode
  logic sel_p2ana;  // Port two mode
  logic sel_p1drv;  // Port one driver
  logic sel_p2drv;  // Port two driver
  logic sel_p1byp;  // Port one bypass

  // Data registers ignore the page selector
  assign sel_p1    = hit_any(i_sfr_addr, PCFG_ADR_P1);    // RULE4
  assign sel_p2    = hit_any(i_sfr_addr, PCFG_ADR_P2);    // RULE4
  // Configuration registers need the config page
  assign sel_p1ana = hit_cfg(i_sfr_page, i_sfr_addr, PCFG_ADR_P1ANA);
  assign sel_p2ana = hit_cfg(i_sfr_page, i_sfr_addr, PCFG_ADR_P2ANA);
  assign sel_p1drv = hit_cfg(i_sfr_page, i_sfr_addr, PCFG_ADR_P1DRV);
  assign sel_p2drv = hit_cfg(i_sfr_page, i_sfr_addr, PCFG_ADR_P2DRV);
  assign sel_p1byp = hit_cfg(i_sfr_page, i_sfr_addr, PCFG_ADR_P1BYP);

  // ==========================================================
  // Output latches
  // ==========================================================
  // Byte write wins over a bit write in the same cycle
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      port_one_pins <= PCFG_RST_DATA;                     // RULE15
      port_two_pins <= PCFG_RST_DATA;                     // RULE15
    end else begin
      port_one_pins <= latch_next(port_one_pins,
                         i_sfr_wr && sel_p1, i_sfr_wdata,
                         i_sfr_bit_wr && sel_p1,
                         i_sfr_bit_sel, i_sfr_bit_val);   // RULE1
      port_two_pins <= latch_next(port_two_pins,
                         i_sfr_wr && sel_p2, i_sfr_wdata,
                         i_sfr_bit_wr && sel_p2,
                         i_sfr_bit_sel, i_sfr_bit_val);   // RULE1
    end
  end

  // ==========================================================
  // Input mode registers
  // ==========================================================
  // Plain storage; value read back as written
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      port_one_analog_select <= PCFG_RST_ANA;             // RULE15
      port_two_analog_select <= PCFG_RST_ANA;             // RULE15
    end else begin
      if (i_sfr_wr && sel_p1ana) begin
        port_one_analog_select <= i_sfr_wdata;            // RULE6
      end
      if (i_sfr_wr && sel_p2ana) begin
        port_two_analog_select <= i_sfr_wdata;            // RULE6
      end
    end
  end

  // ==========================================================
  // Output mode registers
  // ==========================================================
  // Held even for analog pins, so a later switch to
  // digital picks up the stored driver choice at once
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      port_one_driver_type <= PCFG_RST_DRV;               // RULE15
      port_two_driver_type <= PCFG_RST_DRV;               // RULE15
    end else begin
      if (i_sfr_wr && sel_p1drv) begin
        port_one_driver_type <= i_sfr_wdata;              // RULE10
      end
      if (i_sfr_wr && sel_p2drv) begin
        port_two_driver_type <= i_sfr_wdata;              // RULE13
      end
    end
  end

  // ==========================================================
  // Crossbar bypass register
  // ==========================================================
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      port_one_crossbar_bypass <= PCFG_RST_BYP;           // RULE15
    end else if (i_sfr_wr && sel_p1byp) begin
      port_one_crossbar_bypass <= i_sfr_wdata;            // RULE11
    end
  end

  // ==========================================================
  // Read data path
  // ==========================================================
  logic [PCFG_DW-1:0] next_rdata;  // Mux result
  logic               next_hit;    // Address matched

  // Pin reads see the pad, gated by the receiver enable.
  // A disabled receiver reads as zero rather than a float.
  always_comb begin
    next_rdata = PCFG_ZERO;
    next_hit   = 1'b1;
    if (sel_p1) begin
      next_rdata = i_port_one_pin & port_one_analog_select; // RULE2
    end else if (sel_p2) begin
      next_rdata = i_port_two_pin & port_two_analog_select; // RULE3
    end else if (sel_p1ana) begin
      next_rdata = port_one_analog_select;                // RULE14
    end else if (sel_p2ana) begin
      next_rdata = port_two_analog_select;                // RULE14
    end else if (sel_p1drv) begin
      next_rdata = port_one_driver_type;                  // RULE14
    end else if (sel_p2drv) begin
      next_rdata = port_two_driver_type;                  // RULE14
    end else if (sel_p1byp) begin
      next_rdata = port_one_crossbar_bypass;              // RULE14
    end else begin
      // Unmapped or wrong page: zero and no hit
      next_hit = 1'b0;
    end
  end

  // Registered answer, one cycle after the read strobe
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_sfr_rdata <= PCFG_ZERO;
      o_sfr_hit   <= 1'b0;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= next_rdata;
      o_sfr_hit   <= next_hit;
    end else begin
      // Drop the hit flag between reads, keep the data
      o_sfr_hit   <= 1'b0;
    end
  end

  // ==========================================================
  // Pad control, port one
  // ==========================================================
  // Registered from the stored state, so pads settle one
  // cycle after a register write
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_port_one_out    <= PCFG_RST_DATA;
      o_port_one_oe     <= ~PCFG_RST_DATA;
      o_port_one_pullup <= PCFG_RST_ANA;
      o_port_one_rx_en  <= PCFG_RST_ANA;
    end else begin
      o_port_one_out    <= port_one_pins;
      o_port_one_oe     <= drive_en(port_one_pins,
                             port_one_analog_select,
                             port_one_driver_type);       // RULE10
      o_port_one_pullup <= port_one_analog_select;        // RULE7
      o_port_one_rx_en  <= port_one_analog_select;        // RULE7
    end
  end

  // ==========================================================
  // Pad control, port two
  // ==========================================================
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_port_two_out    <= PCFG_RST_DATA;
      o_port_two_oe     <= ~PCFG_RST_DATA;
      o_port_two_pullup <= PCFG_RST_ANA;
      o_port_two_rx_en  <= PCFG_RST_ANA;
    end else begin
      o_port_two_out    <= port_two_pins;
      o_port_two_oe     <= drive_en(port_two_pins,
                             port_two_analog_select,
                             port_two_driver_type);       // RULE13
      o_port_two_pullup <= port_two_analog_select;        // RULE7
      o_port_two_rx_en  <= port_two_analog_select;        // RULE7
    end
  end

  // ==========================================================
  // Crossbar steering
  // ==========================================================
  // The decoder lives elsewhere; it only sees this mask
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_port_one_skip <= PCFG_RST_BYP;
    end else begin
      o_port_one_skip <= port_one_crossbar_bypass;        // RULE11
    end
  end

endmodule

// [test/pcfg_assertions.sv]
// Checker for the two-port register block
`timescale 1ns/100ps
module pcfg_checker (
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  input wire logic [7:0] i_sfr_page,
  input wire logic [7:0] i_sfr_addr,
  input wire logic       i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic       i_sfr_rd,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       o_sfr_hit,
  input wire logic [7:0] i_port_one_pin,
  input wire logic [7:0] o_port_one_out,
  input wire logic [7:0] o_port_one_oe,
  input wire logic [7:0] o_port_one_pullup,
  input wire logic [7:0] o_port_one_rx_en,
  input wire logic [7:0] o_port_two_out,
  input wire logic [7:0] o_port_one_skip
);
  // ==========================================
  // Decode and access sequences
  // ==========================================
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // Paged registers, hidden off the config page
  wire cfg_adr = i_sfr_addr inside {8'hF2, 8'hF3, 8'hA5, 8'hA6, 8'hD5};
  sequence s_one_wr;
    i_sfr_wr && i_sfr_addr == 8'h90;
  endsequence
  sequence s_two_wr;
    i_sfr_wr && i_sfr_addr == 8'hA0;
  endsequence
  // Lone read, so the hit pulse must drop again
  sequence s_cfg_rd;
    i_sfr_rd && cfg_adr && i_sfr_page == 8'h0F ##1 !i_sfr_rd;
  endsequence
  // No write just before, so the mode outputs are current
  sequence s_pin_rd;
    !i_sfr_wr ##1 i_sfr_rd && i_sfr_addr == 8'h90;
  endsequence
  // ==========================================
  // Assertions
  // ==========================================
  a_reset_values: assert property ($rose(i_rst_n) |->
    o_port_one_out == 8'hFF && o_port_one_oe == 8'h00 &&
    o_port_one_skip == 8'h00 && o_port_one_pullup == 8'hFF)
    else $error("pad controls not at reset values");
  a_one_latch: assert property (s_one_wr |=> ##1
    o_port_one_out == $past(i_sfr_wdata, 2))
    else $error("port one latch not loaded");
  a_two_latch: assert property (s_two_wr |=> ##1
    o_port_two_out == $past(i_sfr_wdata, 2))
    else $error("port two latch not loaded");
  a_low_driven: assert property (
    (o_port_one_oe | o_port_one_out) == 8'hFF)
    else $error("low latch bit not driven");
  a_analog_float: assert property (
    (o_port_one_oe & o_port_one_out & ~o_port_one_rx_en) == 8'h00)
    else $error("analog pin driven high");
  a_pull_rx: assert property (
    o_port_one_pullup == o_port_one_rx_en)
    else $error("pull-up and receiver disagree");
  a_off_page: assert property (
    i_sfr_rd && cfg_adr && i_sfr_page != 8'h0F |=> !o_sfr_hit)
    else $error("config register seen off its page");
  a_page_hit: assert property (s_cfg_rd |->
    o_sfr_hit ##1 !o_sfr_hit)
    else $error("config read hit not one cycle");
  a_pin_read: assert property (s_pin_rd |=>
    o_sfr_rdata == ($past(i_port_one_pin) & $past(o_port_one_rx_en)))
    else $error("port one read not masked pin level");
endmodule
bind pcfg_top pcfg_checker u_chk (
  .i_clock, .i_rst_n, .i_sfr_page, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata,
  .i_sfr_rd, .o_sfr_rdata, .o_sfr_hit, .i_port_one_pin, .o_port_one_out,
  .o_port_one_oe, .o_port_one_pullup, .o_port_one_rx_en, .o_port_two_out,
  .o_port_one_skip
);

// [test/pcfg_core_model.sv]
// Core-side model issuing register reads and writes
`timescale 1ns/100ps
module pcfg_core_model (
  input  wire logic       i_clock,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_hit,
  output logic      [7:0] o_page,
  output logic      [7:0] o_addr,
  output logic            o_wr,
  output logic      [7:0] o_wdata,
  output logic            o_bit_wr,
  output logic      [2:0] o_bit_sel,
  output logic            o_bit_val,
  output logic            o_rd
);
  // ==========================================
  // Bus tasks
  // ==========================================
  // Idle bus at time zero, no strobe before reset lifts
  initial begin
    {o_page, o_addr, o_wdata, o_bit_sel} = 27'h0;
    {o_wr, o_bit_wr, o_bit_val, o_rd} = 4'h0;
  end
  // Byte write: one-cycle strobe, fields held to the taking edge
  task automatic wr(input logic [7:0] pg, ad, dt);
    @(posedge i_clock);
    o_page <= pg;
    o_addr <= ad;
    o_wdata <= dt;
    o_wr <= 1'h1;
    @(posedge i_clock);
    o_wr <= 1'h0;
    o_wdata <= ~dt;  // Released data must not look valid
  endtask
  // Single-bit write, page left as it was
  task automatic bw(input logic [7:0] ad, input logic [2:0] sl,
                    input logic v);
    @(posedge i_clock);
    o_addr <= ad;
    o_bit_sel <= sl;
    o_bit_val <= v;
    o_bit_wr <= 1'h1;
    @(posedge i_clock);
    o_bit_wr <= 1'h0;
    o_bit_val <= ~v;
  endtask
  // Read: answer registered at the taking edge
  task automatic rd(input logic [7:0] pg, ad, output logic [7:0] dt,
                    output logic ht);
    @(posedge i_clock);
    o_page <= pg;
    o_addr <= ad;
    o_rd <= 1'h1;
    @(posedge i_clock);
    o_rd <= 1'h0;
    #1;
    dt = i_rdata;
    ht = i_hit;
  endtask
endmodule

// [test/tb_top.sv]
// Self-checking bench for the two-port register block
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
  fail_count++; $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  // ==========================================
  // Bench signals and pads
  // ==========================================
  logic       i_clock = 1'h0;   // 4 ns period
  logic       i_rst_n = 1'h0;   // Sync, active low
  int         fail_count = 0;   // Mismatches
  int         checks_done = 0;  // Comparisons
  logic [7:0] ext_en = 8'h00;   // Outside drivers on port one
  logic [7:0] ext_val = 8'h00;  // Their levels
  logic [7:0] i_sfr_page, i_sfr_addr, i_sfr_wdata, o_sfr_rdata;
  logic       i_sfr_wr, i_sfr_bit_wr, i_sfr_bit_val, i_sfr_rd, o_sfr_hit;
  logic [2:0] i_sfr_bit_sel;
  logic [7:0] i_port_one_pin, i_port_two_pin, o_port_one_out, o_port_one_oe;
  logic [7:0] o_port_one_pullup, o_port_one_rx_en, o_port_one_skip;
  logic [7:0] o_port_two_out, o_port_two_oe, o_port_two_pullup;
  logic [7:0] o_port_two_rx_en;
  always #2 i_clock = ~i_clock;
  // Undriven lines float high, so a missing analog mask shows up
  assign i_port_one_pin = (o_port_one_oe & o_port_one_out) |
    (~o_port_one_oe & ((ext_en & ext_val) | ~ext_en));
  assign i_port_two_pin = (o_port_two_oe & o_port_two_out) | ~o_port_two_oe;
  pcfg_top dut (
    .i_clock, .i_rst_n, .i_sfr_page, .i_sfr_addr, .i_sfr_wr, .i_sfr_wdata,
    .i_sfr_bit_wr, .i_sfr_bit_sel, .i_sfr_bit_val, .i_sfr_rd, .o_sfr_rdata,
    .o_sfr_hit, .i_port_one_pin, .i_port_two_pin, .o_port_one_out,
    .o_port_one_oe, .o_port_one_pullup, .o_port_one_rx_en, .o_port_two_out,
    .o_port_two_oe, .o_port_two_pullup, .o_port_two_rx_en, .o_port_one_skip
  );
  pcfg_core_model core (
    .i_clock(i_clock), .i_rdata(o_sfr_rdata), .i_hit(o_sfr_hit),
    .o_page(i_sfr_page), .o_addr(i_sfr_addr), .o_wr(i_sfr_wr),
    .o_wdata(i_sfr_wdata), .o_bit_wr(i_sfr_bit_wr),
    .o_bit_sel(i_sfr_bit_sel), .o_bit_val(i_sfr_bit_val), .o_rd(i_sfr_rd)
  );
  // ==========================================
  // Shared tasks
  // ==========================================
  task automatic rchk(input logic [7:0] pg, ad, ex, input logic eh);
    logic [7:0] dt;
    logic       ht;
    core.rd(pg, ad, dt, ht);
    `CHK("read data", ex, dt)
    `CHK("read hit", eh, ht)
  endtask
  // Pads follow the registers one edge later
  task automatic settle;
    @(posedge i_clock);
    #1;
  endtask
  task automatic pads(input logic [7:0] ou, oe, pu, sk);
    `CHK("one out", ou, o_port_one_out)
    `CHK("one oe", oe, o_port_one_oe)
    `CHK("one pullup", pu, o_port_one_pullup)
    `CHK("one skip", sk, o_port_one_skip)
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  // ==========================================
  task automatic t_reset;
    logic [7:0] ad [7] = '{8'hF2, 8'hF3, 8'hA5, 8'hA6, 8'hD5, 8'h90, 8'hA0};
    logic [7:0] ex [7] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF};
    @(posedge i_clock);
    i_rst_n <= 1'h0;
    repeat (5) @(posedge i_clock);
    i_rst_n <= 1'h1;
    #1;
    pads(8'hFF, 8'h00, 8'hFF, 8'h00);
    `CHK("two oe rst", 8'h00, o_port_two_oe)
    `CHK("two pullup rst", 8'hFF, o_port_two_pullup)
    foreach (ad[k]) rchk(8'h0F, ad[k], ex[k], 1'h1);
  endtask
  // Latch written off the config page, pin overridden from outside
  task automatic t_data;
    core.wr(8'h00, 8'h90, 8'h55);
    settle;
    pads(8'h55, 8'hAA, 8'hFF, 8'h00);
    rchk(8'h00, 8'h90, 8'h55, 1'h1);
    @(posedge i_clock);
    ext_en <= 8'h01;
    rchk(8'h0F, 8'h90, 8'h54, 1'h1);
    core.bw(8'h90, 3'h0, 1'h0);
    ext_en <= 8'h00;
    settle;
    `CHK("bit write", 8'h54, o_port_one_out)
    core.wr(8'h0F, 8'hA0, 8'h3C);
    settle;
    `CHK("two out", 8'h3C, o_port_two_out)
    core.bw(8'hA0, 3'h1, 1'h1);
    settle;
    `CHK("two bit set", 8'h3E, o_port_two_out)
    rchk(8'h0F, 8'hA0, 8'h3E, 1'h1);
  endtask
  // Port one upper, port two lower pins analog, push-pull bits left set
  task automatic t_cfg;
    core.wr(8'h0F, 8'hF2, 8'h0F);
    core.wr(8'h0F, 8'hA5, 8'hFF);
    core.wr(8'h0F, 8'hD5, 8'hF0);
    core.wr(8'h0F, 8'hF3, 8'hF0);
    core.wr(8'h0F, 8'hA6, 8'h0F);
    settle;
    pads(8'h54, 8'hAF, 8'h0F, 8'hF0);
    `CHK("two oe", 8'hC1, o_port_two_oe)
    `CHK("two pullup", 8'hF0, o_port_two_pullup)
    `CHK("one rx", 8'h0F, o_port_one_rx_en)
    `CHK("two rx", 8'hF0, o_port_two_rx_en)
    rchk(8'h0F, 8'hA5, 8'hFF, 1'h1);
    rchk(8'h0F, 8'hD5, 8'hF0, 1'h1);
    rchk(8'h0F, 8'hF3, 8'hF0, 1'h1);
    rchk(8'h0F, 8'hA6, 8'h0F, 1'h1);
    rchk(8'h00, 8'h90, 8'h04, 1'h1);
    rchk(8'h00, 8'hA0, 8'h30, 1'h1);
  endtask
  // Paging, unmapped address, bit write to a config address while still off the config page
  task automatic t_page;
    core.wr(8'h0F, 8'hA5, 8'h0F);
    core.wr(8'h00, 8'hF2, 8'h00);
    core.bw(8'hF2, 3'h4, 1'h1);
    rchk(8'h00, 8'hF2, 8'h00, 1'h0);
    rchk(8'h0F, 8'hF2, 8'h0F, 1'h1);
    rchk(8'h0F, 8'hA5, 8'h0F, 1'h1);
    rchk(8'h0F, 8'h91, 8'h00, 1'h0);
  endtask
  initial begin
    t_reset;
    t_data;
    t_cfg;
    t_page;
    t_reset;
    give_verdict;
  end
  // Watchdog: whole run needs about 100 cycles
  initial begin
    repeat (1000) @(posedge i_clock);
    fail_count++;
    give_verdict;
  end
endmodule
